/* File: design/hpr_pkg.sv */
// Constants shared by the hibernation power and seconds-counter block.
// Assumes a 10 MHz ref_clk; the 32.768 kHz reference is a clock enable tick.
package hpr_pkg;
    // ---------------------------------------------------------------
    // Clock source
    // ---------------------------------------------------------------
    localparam int unsigned CRYSTAL_DIVIDE    = 128;
    localparam logic [6:0]  CRYSTAL_DIV_LAST  = 7'h7f;
    localparam logic        SEL_CRYSTAL       = 1'b0;
    localparam logic        SEL_DIRECT        = 1'b1;
    // ---------------------------------------------------------------
    // Seconds counter
    // ---------------------------------------------------------------
    localparam logic [15:0] TRIM_NOMINAL      = 16'h7fff;
    localparam logic [5:0]  TRIM_PERIOD_LAST  = 6'h3f;
    localparam logic [31:0] MATCH_RESET       = 32'hffffffff;
    localparam logic [31:0] LOAD_RESET        = 32'hffffffff;
    // ---------------------------------------------------------------
    // Retained memory
    // ---------------------------------------------------------------
    localparam int unsigned MEM_WORDS         = 64;
    localparam int unsigned MEM_AW            = 6;
    // ---------------------------------------------------------------
    // Event bit positions
    // ---------------------------------------------------------------
    localparam int unsigned EV_MATCH0         = 0;
    localparam int unsigned EV_MATCH1         = 1;
    localparam int unsigned EV_LOW_BATTERY_FLAG         = 2;
    localparam int unsigned EV_PIN            = 3;
    localparam int unsigned EV_W              = 4;
    localparam logic [3:0]  EV_RESET          = 4'h0;
    // ---------------------------------------------------------------
    // Power states
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        HPR_AWAKE = 2'b01,
        HPR_SLEEP = 2'b10
    } hpr_state_type;
endpackage : hpr_pkg

/* File: design/hpr_hibernate.sv */
// Hibernation power controller with seconds counter, matches and retained memory.
// Assumes all inputs synchronous to ref_clk; oscillator input arrives already sampled.
`timescale 1ns/1ns
// Operation
// - Crystal source divided by 128 to reference
// - Reference runs only with source enabled
// - Select zero divides, one passes direct
// - Low battery sets flag when enabled
// - Low battery with abort blocks hibernation
// - No battery evaluation while hibernated
// - Predivider advances 32-bit seconds counter
// - Trim divisor used once per 64 seconds
// - Larger trim slows, smaller trim speeds
// - Two match compares wake or interrupt
// - Counter advances only when enabled
// - Load write sets counter any time
// - Sixty-four retained 32-bit memory words
// - Power-off output asserted entering hibernation
// - Wake deasserts power-off output
// - Sleep request starts hibernation
// - Wake on enabled pin or match
// - Wake cause stays in raw status
// - Events ORed into one interrupt
// - Raw shows all, masked shows driving
// - Mask gates interrupt, clear write clears
module hpr_hibernate (
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic        osc_in_pin,
    input  wire logic        clock_source_enable,
    input  wire logic        clock_source_select,
    input  wire logic        counter_enable,
    input  wire logic        low_battery_detect_enable,
    input  wire logic        abort_on_low_battery,
    input  wire logic        pin_wake_enable,
    input  wire logic        match_wake_enable,
    input  wire logic        sleep_request,
    input  wire logic        battery_below_threshold,
    input  wire logic        wake_pin_n,
    input  wire logic        rate_trim_write,
    input  wire logic [15:0] rate_trim_wdata,
    input  wire logic        counter_load_write,
    input  wire logic [31:0] counter_load_wdata,
    input  wire logic        match_value_0_write,
    input  wire logic [31:0] match_value_0_wdata,
    input  wire logic        match_value_1_write,
    input  wire logic [31:0] match_value_1_wdata,
    input  wire logic        mem_write,
    input  wire logic [5:0]  mem_addr,
    input  wire logic [31:0] mem_wdata,
    input  wire logic [3:0]  event_mask,
    input  wire logic        event_clear_write,
    input  wire logic [3:0]  event_clear,
    output logic             power_off_request_n,
    output logic             interrupt_request,
    output logic [3:0]       raw_event_status,
    output logic [3:0]       masked_event_status,
    output logic [31:0]      seconds_count,
    output logic [15:0]      rate_trim_register,
    output logic [31:0]      counter_load_register,
    output logic [31:0]      match_value_0,
    output logic [31:0]      match_value_1,
    output logic [31:0]      mem_rdata,
    output logic             low_battery_flag,
    output logic             hibernated
);
    // ---------------------------------------------------------------
    // Reference tick
    // ---------------------------------------------------------------
    logic [6:0]  xdiv;
    logic        osc_prev;
    logic        osc_rise;
    logic        ref_tick;
    hpr_pkg::hpr_state_type state;

    assign osc_rise = osc_in_pin & ~osc_prev;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            osc_prev <= 1'b0;
            xdiv     <= 7'h00;
            ref_tick <= 1'b0;
        end else begin
            osc_prev <= osc_in_pin;
            ref_tick <= 1'b0;
            if (!clock_source_enable) begin
                xdiv <= 7'h00;
            end else if (osc_rise) begin
                if (clock_source_select == hpr_pkg::SEL_DIRECT) begin
                    ref_tick <= 1'b1;
                end else begin
                    xdiv <= xdiv + 7'h01;
                    ref_tick <= (xdiv == hpr_pkg::CRYSTAL_DIV_LAST);
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // Predivider and seconds counter
    // ---------------------------------------------------------------
    logic [15:0] prediv;
    logic [5:0]  sec_phase;
    logic        sec_tick;
    logic [15:0] next_prediv;

    assign sec_tick = ref_tick & counter_enable & (prediv == 16'h0000);
    // Reload is trim on the last second of each 64, nominal otherwise
    assign next_prediv = (sec_phase == hpr_pkg::TRIM_PERIOD_LAST) ?
                         rate_trim_register : hpr_pkg::TRIM_NOMINAL;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            prediv    <= hpr_pkg::TRIM_NOMINAL;
            sec_phase <= 6'h00;
        end else if (ref_tick && counter_enable) begin
            if (prediv == 16'h0000) begin
                prediv    <= next_prediv;
                sec_phase <= sec_phase + 6'h01;
            end else begin
                prediv <= prediv - 16'h0001;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            seconds_count <= 32'h00000000;
        end else if (counter_load_write) begin
            seconds_count <= counter_load_wdata;
        end else if (sec_tick) begin
            seconds_count <= seconds_count + 32'h00000001;
        end
    end

    // ---------------------------------------------------------------
    // Software-written registers
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rate_trim_register    <= hpr_pkg::TRIM_NOMINAL;
            counter_load_register <= hpr_pkg::LOAD_RESET;
            match_value_0         <= hpr_pkg::MATCH_RESET;
            match_value_1         <= hpr_pkg::MATCH_RESET;
        end else begin
            if (rate_trim_write) begin
                rate_trim_register <= rate_trim_wdata;
            end
            if (counter_load_write) begin
                counter_load_register <= counter_load_wdata;
            end
            if (match_value_0_write) begin
                match_value_0 <= match_value_0_wdata;
            end
            if (match_value_1_write) begin
                match_value_1 <= match_value_1_wdata;
            end
        end
    end

    // ---------------------------------------------------------------
    // Retained memory
    // ---------------------------------------------------------------
    logic [31:0] mem [hpr_pkg::MEM_WORDS];

    generate
        for (genvar i = 0; i < hpr_pkg::MEM_WORDS; i++) begin : g_mem
            always_ff @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    mem[i] <= 32'h00000000;
                end else if (mem_write && mem_addr == 6'(i)) begin
                    mem[i] <= mem_wdata;
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            mem_rdata <= 32'h00000000;
        end else begin
            mem_rdata <= mem[mem_addr];
        end
    end

    // ---------------------------------------------------------------
    // Events
    // ---------------------------------------------------------------
    logic [3:0] ev_set;
    logic [3:0] next_raw;
    logic       low_battery_flag_now;
    logic       match_any;

    assign low_battery_flag_now = low_battery_detect_enable & battery_below_threshold
                        & (state == hpr_pkg::HPR_AWAKE);
    assign ev_set[hpr_pkg::EV_MATCH0] = (seconds_count == match_value_0);
    assign ev_set[hpr_pkg::EV_MATCH1] = (seconds_count == match_value_1);
    assign ev_set[hpr_pkg::EV_LOW_BATTERY_FLAG] = low_battery_flag_now;
    assign ev_set[hpr_pkg::EV_PIN]    = ~wake_pin_n;
    assign match_any = ev_set[hpr_pkg::EV_MATCH0] | ev_set[hpr_pkg::EV_MATCH1];
    // Set wins over a clear in the same cycle; zero clear bits do nothing
    assign next_raw = (raw_event_status & ~(event_clear_write ? event_clear : 4'h0))
                      | ev_set;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            raw_event_status    <= hpr_pkg::EV_RESET;
            masked_event_status <= hpr_pkg::EV_RESET;
            interrupt_request   <= 1'b0;
            low_battery_flag    <= 1'b0;
        end else begin
            raw_event_status    <= next_raw;
            masked_event_status <= next_raw & event_mask;
            interrupt_request   <= |(next_raw & event_mask);
            low_battery_flag    <= next_raw[hpr_pkg::EV_LOW_BATTERY_FLAG];
        end
    end

    // ---------------------------------------------------------------
    // Power state
    // ---------------------------------------------------------------
    logic wake_now;
    logic sleep_ok;

    assign wake_now = (pin_wake_enable & ~wake_pin_n)
                      | (match_wake_enable & match_any);
    assign sleep_ok = ~(abort_on_low_battery & low_battery_flag_now);

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state               <= hpr_pkg::HPR_AWAKE;
            power_off_request_n <= 1'b1;
            hibernated          <= 1'b0;
        end else begin
            case (state)
                hpr_pkg::HPR_AWAKE: begin
                    if (sleep_request && sleep_ok) begin
                        state               <= hpr_pkg::HPR_SLEEP;
                        power_off_request_n <= 1'b0;
                        hibernated          <= 1'b1;
                    end
                end
                hpr_pkg::HPR_SLEEP: begin
                    if (wake_now) begin
                        state               <= hpr_pkg::HPR_AWAKE;
                        power_off_request_n <= 1'b1;
                        hibernated          <= 1'b0;
                    end
                end
                default: begin
                    state               <= hpr_pkg::HPR_AWAKE;
                    power_off_request_n <= 1'b1;
                    hibernated          <= 1'b0;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    property p_off_on_sleep;
        @(posedge ref_clk) disable iff (!resetn)
        (state == hpr_pkg::HPR_AWAKE && sleep_request && sleep_ok) |=> !power_off_request_n;
    endproperty
    a_off_on_sleep: assert property (p_off_on_sleep) else $error("power off not asserted");

    property p_wake;
        @(posedge ref_clk) disable iff (!resetn)
        (state == hpr_pkg::HPR_SLEEP && wake_now) |=> power_off_request_n;
    endproperty
    a_wake: assert property (p_wake) else $error("wake did not restore power");

    property p_abort;
        @(posedge ref_clk) disable iff (!resetn)
        (state == hpr_pkg::HPR_AWAKE && abort_on_low_battery && low_battery_flag_now)
        |=> state == hpr_pkg::HPR_AWAKE;
    endproperty
    a_abort: assert property (p_abort) else $error("slept on low battery");

    property p_no_meas;
        @(posedge ref_clk) disable iff (!resetn)
        (state == hpr_pkg::HPR_SLEEP) |-> !low_battery_flag_now;
    endproperty
    a_no_meas: assert property (p_no_meas) else $error("battery measured asleep");

    property p_load;
        @(posedge ref_clk) disable iff (!resetn)
        counter_load_write |=> seconds_count == $past(counter_load_wdata);
    endproperty
    a_load: assert property (p_load) else $error("load not applied");

    property p_hold;
        @(posedge ref_clk) disable iff (!resetn)
        (!counter_enable && !counter_load_write) |=> $stable(seconds_count);
    endproperty
    a_hold: assert property (p_hold) else $error("counter moved while disabled");

    property p_masked;
        @(posedge ref_clk) disable iff (!resetn)
        masked_event_status == (raw_event_status & $past(event_mask));
    endproperty
    a_masked: assert property (p_masked) else $error("masked status wrong");

    property p_irq;
        @(posedge ref_clk) disable iff (!resetn)
        interrupt_request == (|masked_event_status);
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not OR of masked");

    property p_set_wins;
        @(posedge ref_clk) disable iff (!resetn)
        ev_set[hpr_pkg::EV_PIN] |=> raw_event_status[hpr_pkg::EV_PIN];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("pin event lost");

    property p_div;
        @(posedge ref_clk) disable iff (!resetn)
        ref_tick && clock_source_select == hpr_pkg::SEL_CRYSTAL && $stable(clock_source_select)
        |-> $past(xdiv) == hpr_pkg::CRYSTAL_DIV_LAST;
    endproperty
    a_div: assert property (p_div) else $error("crystal divide wrong");
endmodule : hpr_hibernate

/* File: bench/hpr_supply_model.sv */
// Model of the external regulator and backup battery beside the block.
// Assumes power_off_request_n low turns the regulator off.
`timescale 1ns/1ns
module hpr_supply_model (
    input  wire logic ref_clk,
    input  wire logic power_off_request_n,
    input  wire logic battery_low_cmd,
    output logic      battery_below_threshold,
    output logic      main_supply_on
);
    logic [1:0] ramp = 2'h3;
    // Comparator follows the commanded battery level
    assign battery_below_threshold = battery_low_cmd;
    // Regulator output follows its enable two cycles later
    always @(posedge ref_clk) begin
        ramp <= {ramp[0], power_off_request_n};
    end
    assign main_supply_on = ramp[1];
endmodule : hpr_supply_model

/* File: bench/tb.sv */
// Self-checking bench for the hibernation power and seconds-counter block.
// Assumes the supply model and a 10 MHz ref_clk.
`timescale 1ns/1ns
module tb;
    localparam int SETTLE = 8;
    logic        ref_clk = 0, resetn = 0, osc_in_pin = 0, bat_low = 0, sleep_request = 0;
    logic        clock_source_enable = 0, clock_source_select = 0, counter_enable = 0;
    logic        low_battery_detect_enable = 0, abort_on_low_battery = 0, wake_pin_n = 1;
    logic        pin_wake_enable = 0, match_wake_enable = 0, mem_write = 0;
    logic        rate_trim_write = 0, counter_load_write = 0, event_clear_write = 0;
    logic        match_value_0_write = 0, match_value_1_write = 0, battery_below_threshold;
    logic        power_off_request_n, interrupt_request, low_battery_flag, hibernated;
    logic        main_supply_on;
    logic [15:0] rate_trim_wdata = 0, rate_trim_register;
    logic [31:0] counter_load_wdata = 0, match_value_0_wdata = 0, match_value_1_wdata = 0;
    logic [31:0] mem_wdata = 0, mem_rdata, seconds_count, counter_load_register;
    logic [31:0] match_value_0, match_value_1, r;
    logic [31:0] mem_m [64];
    logic [5:0]  mem_addr = 0;
    logic [3:0]  event_mask = 0, event_clear = 0, raw_event_status, masked_event_status;
    logic [3:0]  raw_m;
    int          fail_count = 0, checks_done = 0, div_m, pre_m, sec_m;

    hpr_hibernate u_hpr_hibernate (
        .ref_clk, .resetn, .osc_in_pin, .clock_source_enable, .clock_source_select,
        .counter_enable, .low_battery_detect_enable, .abort_on_low_battery,
        .pin_wake_enable, .match_wake_enable, .sleep_request, .battery_below_threshold,
        .wake_pin_n, .rate_trim_write, .rate_trim_wdata, .counter_load_write,
        .counter_load_wdata, .match_value_0_write, .match_value_0_wdata,
        .match_value_1_write, .match_value_1_wdata, .mem_write, .mem_addr, .mem_wdata,
        .event_mask, .event_clear_write, .event_clear, .power_off_request_n,
        .interrupt_request, .raw_event_status, .masked_event_status, .seconds_count,
        .rate_trim_register, .counter_load_register, .match_value_0, .match_value_1,
        .mem_rdata, .low_battery_flag, .hibernated
    );
    hpr_supply_model u_hpr_supply_model (
        .ref_clk, .power_off_request_n, .battery_low_cmd(bat_low),
        .battery_below_threshold, .main_supply_on
    );

    always #50 ref_clk = ~ref_clk;

    // ---------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : cyc

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk_val

    task automatic chk_stat();
        logic [3:0] m;
        m = raw_m & event_mask;
        chk_val({interrupt_request, low_battery_flag, masked_event_status, raw_event_status},
                {|m, raw_m[2], m, raw_m});
    endtask : chk_stat

    task automatic wr(input int sel, input logic [31:0] d);
        rate_trim_write = (sel == 0);
        counter_load_write = (sel == 1);
        match_value_0_write = (sel == 2);
        match_value_1_write = (sel == 3);
        mem_write = (sel == 4);
        {rate_trim_wdata, counter_load_wdata, match_value_0_wdata} = {d[15:0], d, d};
        {match_value_1_wdata, mem_wdata} = {d, d};
        cyc(1);
        {rate_trim_write, counter_load_write, match_value_0_write} = 3'h0;
        {match_value_1_write, mem_write} = 2'h0;
        cyc(1);
    endtask : wr

    task automatic clr(input logic [3:0] b);
        event_clear = b;
        event_clear_write = 1'b1;
        cyc(1);
        event_clear_write = 1'b0;
        cyc(1);
    endtask : clr

    task automatic osc_edge(input bit fast = 1'b0);
        logic tick;
        osc_in_pin = 1'b1;
        cyc(fast ? 1 : 2);
        osc_in_pin = 1'b0;
        cyc(fast ? 1 : 3);
        tick = clock_source_enable && (clock_source_select || div_m == 127);
        div_m = (clock_source_enable && !clock_source_select) ? (div_m + 1) % 128 : 0;
        if (tick && counter_enable) begin
            sec_m = (pre_m == 0) ? sec_m + 1 : sec_m;
            pre_m = (pre_m == 0) ? 32'h7fff : pre_m - 1;
        end
        chk_val(seconds_count, sec_m);
    endtask : osc_edge

    task automatic do_reset();
        resetn = 1'b0;
        cyc(3);
        resetn = 1'b1;
        {div_m, sec_m, raw_m} = '0;
        pre_m = hpr_pkg::TRIM_NOMINAL;
        chk_val({15'h0000, power_off_request_n, rate_trim_register}, 32'h0001_7fff);
        chk_val(seconds_count, 32'h0000_0000);
        chk_val(counter_load_register & match_value_0 & match_value_1, 32'hffffffff);
        chk_stat();
    endtask : do_reset

    task automatic stop_test();
        $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test

    // ---------------------------------------------------------------
    // Sequence
    // ---------------------------------------------------------------
    initial begin
        #9000000;
        fail_count++;
        stop_test();
    end

    initial begin
        void'($urandom(39225));
        do_reset();
        counter_enable = 1'b1;
        repeat (100) osc_edge();
        clock_source_enable = 1'b1;
        counter_enable = 1'b0;
        cyc(SETTLE);
        repeat (130) osc_edge();
        counter_enable = 1'b1;
        repeat (130) osc_edge();
        clock_source_select = 1'b1;
        repeat (20) osc_edge();
        repeat (32768) osc_edge(1'b1);
        r = $urandom;
        wr(0, r);
        chk_val(rate_trim_register, {16'h0, r[15:0]});
        for (int i = 0; i < 8; i++) begin
            mem_addr = 6'(i * 9);
            mem_m[i * 9] = $urandom;
            wr(4, mem_m[i * 9]);
        end
        wr(2, r);
        wr(1, r);
        sec_m = r;
        chk_val(seconds_count & counter_load_register, r);
        cyc(2);
        raw_m = 4'h1;
        chk_stat();
        wr(3, r);
        cyc(2);
        raw_m = 4'h3;
        clr(4'h3);
        chk_stat();
        wr(1, r + 32'h5);
        clr(4'h0);
        chk_stat();
        clr(4'h2);
        raw_m = 4'h1;
        chk_stat();
        clr(4'h1);
        {low_battery_detect_enable, abort_on_low_battery, pin_wake_enable, bat_low} = 4'hf;
        cyc(2);
        raw_m = 4'h4;
        chk_stat();
        sleep_request = 1'b1;
        cyc(2);
        sleep_request = 1'b0;
        chk_val({hibernated, power_off_request_n}, 2'b01);
        {abort_on_low_battery, bat_low} = 2'b00;
        cyc(1);
        clr(4'h4);
        raw_m = 4'h0;
        sleep_request = 1'b1;
        cyc(1);
        sleep_request = 1'b0;
        bat_low = 1'b1;
        cyc(3);
        chk_val({hibernated, power_off_request_n, main_supply_on}, 3'b100);
        chk_stat();
        bat_low = 1'b0;
        wake_pin_n = 1'b0;
        cyc(2);
        raw_m = 4'h8;
        chk_val({hibernated, power_off_request_n}, 2'b01);
        chk_stat();
        wake_pin_n = 1'b1;
        clr(4'h8);
        {pin_wake_enable, match_wake_enable} = 2'b01;
        r = $urandom;
        wr(3, r);
        sleep_request = 1'b1;
        cyc(1);
        {sleep_request, wake_pin_n} = 2'b00;
        cyc(3);
        wake_pin_n = 1'b1;
        chk_val(hibernated, 1);
        wr(1, r);
        cyc(3);
        raw_m = 4'ha;
        chk_val({hibernated, power_off_request_n}, 2'b01);
        for (int m = 0; m < 16; m++) begin
            event_mask = 4'(m);
            cyc(3);
            chk_stat();
        end
        for (int i = 0; i < 8; i++) begin
            mem_addr = 6'(i * 9);
            cyc(1);
            chk_val(mem_rdata, mem_m[i * 9]);
        end
        do_reset();
        stop_test();
    end
endmodule : tb
